// ### hw/conditional_table_selector.sv
// Summary of operation
// - Three slots, each picks one of eight tables
// - Selected table value forwarded unchanged
// - Works only when enabled; reset disabled
// - Slots evaluated ascending; first selected wins
// - Default-table slot selected unconditionally
// - Three independent conditions per slot
// - First argument is a block output
// - Second argument is block output or constant
// - Compare codes: eq ne gt ge lt le
// - Operator resets equal; changes need valid sources
// - Sources reset unused; unused gives not-applicable
// - Result codes false true error not-applicable
// - Error flags error; unavailable gives not-applicable
// - Combine codes default and or andor orand
// - All-AND: false/error block, N/A true
// - All-OR: any true selects
// - (c1 and c2) or c3 selects
// - (c1 or c2) and c3 selects
// - Reset combines: AND, AND, default
// - Sourceless table flags output not available
// - No rescaling between table and output
`timescale 1ns/10ps
`default_nettype none
module conditional_table_selector
  import selector_pkg::*;
(
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic                            enable_in,
  input  wire logic                            update_tick,
  input  wire logic                            cfg_write,
  input  wire logic [1:0]                      cfg_slot,
  input  wire logic [1:0]                      cfg_cond,
  input  wire cond_cfg_t                       cfg_cond_data,
  input  wire logic [2:0]                      cfg_combine,
  input  wire logic [2:0]                      cfg_table,
  input  wire arg_t  [TABLE_COUNT*2-1:0]       block_outputs,
  input  wire table_out_t [TABLE_COUNT-1:0]    tables,
  output logic                                 enabled,
  output logic [1:0]                           selected_slot,
  output logic [VALUE_W-1:0]                   out_value,
  output logic                                 out_avail,
  output logic [17:0]                          cond_results
);

  // ==========================================================================
  // Configuration storage
  cond_cfg_t  cond_cfg [SLOT_COUNT][COND_COUNT];
  logic [2:0] combine  [SLOT_COUNT];
  logic [2:0] table_ix [SLOT_COUNT];

  function automatic logic src_valid(input logic [SRC_W-1:0] s);
    return s != SRC_NOT_USED;
  endfunction

  // An operator change is only accepted with both sources valid, so the
  // stored operator of a disabled condition keeps its last value, equal after reset.
  wire cond_cfg_t cur_cfg   = cond_cfg[cfg_slot][cfg_cond];
  wire            op_ok     = src_valid(cfg_cond_data.src1) && src_valid(cfg_cond_data.src2);
  wire            addr_ok   = (cfg_slot < 2'h3) && (cfg_cond < 2'h3);
  wire [2:0]      next_op   = op_ok ? cfg_cond_data.op : cur_cfg.op;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enabled <= 1'b0;
      for (int s = 0; s < SLOT_COUNT; s++) begin
        for (int c = 0; c < COND_COUNT; c++) begin
          cond_cfg[s][c] <= '0;
        end
        combine[s]  <= (s == SLOT_COUNT - 1) ? COMB_DEFAULT : COMB_ALL_AND;
        table_ix[s] <= 3'(s);
      end
    end else begin
      enabled <= enable_in;
      if (cfg_write && addr_ok) begin
        cond_cfg[cfg_slot][cfg_cond]    <= cfg_cond_data;
        cond_cfg[cfg_slot][cfg_cond].op <= next_op;
        combine[cfg_slot]               <= cfg_combine;
        table_ix[cfg_slot]              <= cfg_table;
      end
    end
  end

  // ==========================================================================
  // Condition evaluation
  function automatic logic [1:0] eval_cond(input cond_cfg_t cc, input arg_t a1, input arg_t a2);
    logic t;
    t = 1'b0;
    if (!src_valid(cc.src1) || !src_valid(cc.src2) || !a1.avail || !a2.avail) begin
      return RES_NA;
    end
    if (a1.error || a2.error) begin
      return RES_ERROR;
    end
    case (cc.op)
      CMP_EQ:  t = a1.value == a2.value;
      CMP_NE:  t = a1.value != a2.value;
      CMP_GT:  t = a1.value >  a2.value;
      CMP_GE:  t = a1.value >= a2.value;
      CMP_LT:  t = a1.value <  a2.value;
      CMP_LE:  t = a1.value <= a2.value;
      default: t = 1'b0;
    endcase
    return t ? RES_TRUE : RES_FALSE;
  endfunction

  // Block outputs are indexed by type in bit 0 and instance in the rest;
  // a wider source map lives in the feeding logic.
  function automatic arg_t pick_arg(input arg_t [TABLE_COUNT*2-1:0] bo,
                                    input logic [SRC_W-1:0] s, input logic [INST_W-1:0] n);
    return bo[{n[2:0], s[0]}];
  endfunction

  function automatic logic slot_hit(input logic [2:0] op, input logic [5:0] r);
    logic c1;
    logic c2;
    logic c3;
    logic f1;
    logic f2;
    logic f3;
    c1 = r[1:0] == RES_TRUE;
    c2 = r[3:2] == RES_TRUE;
    c3 = r[5:4] == RES_TRUE;
    f1 = r[1:0] == RES_FALSE || r[1:0] == RES_ERROR;
    f2 = r[3:2] == RES_FALSE || r[3:2] == RES_ERROR;
    f3 = r[5:4] == RES_FALSE || r[5:4] == RES_ERROR;
    case (op)
      COMB_DEFAULT: return 1'b1;
      COMB_ALL_AND: return !(f1 || f2 || f3);
      COMB_ALL_OR:  return c1 || c2 || c3;
      COMB_AND_OR:  return (c1 && c2) || c3;
      COMB_OR_AND:  return (c1 || c2) && c3;
      default:      return 1'b0;
    endcase
  endfunction

  logic [17:0] results;
  logic [2:0]  hits;
  always_comb begin
    arg_t a1;
    arg_t a2;
    a1 = '0;
    a2 = '0;
    for (int s = 0; s < SLOT_COUNT; s++) begin
      for (int c = 0; c < COND_COUNT; c++) begin
        a1 = pick_arg(block_outputs, cond_cfg[s][c].src1, cond_cfg[s][c].num1);
        a2 = pick_arg(block_outputs, cond_cfg[s][c].src2, cond_cfg[s][c].num2);
        if (cond_cfg[s][c].src2 == SRC_CONSTANT) begin
          a2 = '{value: cond_cfg[s][c].constant, error: 1'b0, avail: 1'b1};
        end
        results[s*6+c*2 +: 2] = eval_cond(cond_cfg[s][c], a1, a2);
      end
      hits[s] = slot_hit(combine[s], results[s*6 +: 6]);
    end
  end

  // Priority order: slot 0 first; later slots only matter if earlier miss.
  wire [1:0] next_slot = hits[0] ? 2'h0 : hits[1] ? 2'h1 : hits[2] ? 2'h2 : NO_SLOT[1:0];
  wire table_out_t sel_tab = tables[table_ix[next_slot[1:0] == 2'h3 ? 2'h0 : next_slot]];

  // ==========================================================================
  // Output register, refreshed on each update tick while enabled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      selected_slot <= NO_SLOT[1:0];
      out_value     <= '0;
      out_avail     <= 1'b0;
      cond_results  <= {9{RES_NA}};
    end else if (!enabled) begin
      selected_slot <= NO_SLOT[1:0];
      out_avail     <= 1'b0;
    end else if (update_tick) begin
      selected_slot <= next_slot;
      cond_results  <= results;
      out_value     <= sel_tab.value;
      out_avail     <= (next_slot != NO_SLOT[1:0]) && sel_tab.has_source;
    end
  end

  // ==========================================================================
  // Checks on reset and enable
  // The reset checks look one edge after release, when the cleared state
  // is first visible to a property that is not disabled.
  AST_RESET_COMBINE: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> combine[0] == COMB_ALL_AND && combine[1] == COMB_ALL_AND && combine[2] == COMB_DEFAULT)
    else $error("combine settings not at reset values");

  AST_RESET_DISABLED: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> !enabled && !out_avail && selected_slot == NO_SLOT)
    else $error("block not disabled after reset");

  AST_RESET_OPS: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> cond_cfg[0][0].op == CMP_EQ && cond_cfg[1][2].op == CMP_EQ)
    else $error("operator not equal after reset");

  AST_RESET_SOURCES: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> cond_cfg[0][0].src2 == SRC_NOT_USED && cond_cfg[2][2].src1 == SRC_NOT_USED)
    else $error("sources not unused after reset");

  AST_DISABLED_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    !enabled |=> !out_avail)
    else $error("output available while disabled");

  AST_DISABLED_SLOT: assert property (@(posedge sys_clk) disable iff (rst)
    !enabled |=> selected_slot == NO_SLOT)
    else $error("slot selected while disabled");

  AST_ENABLE_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> enabled == $past(enable_in))
    else $error("enable not registered");

  // ==========================================================================
  // Checks on slot selection and output
  AST_PRIORITY: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick && hits[0] |=> selected_slot == 2'h0)
    else $error("lower slot not preferred");

  AST_SECOND_SLOT: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick && !hits[0] && hits[1] |=> selected_slot == 2'h1)
    else $error("second slot not chosen");

  AST_THIRD_SLOT: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick && !hits[0] && !hits[1] && hits[2] |=> selected_slot == 2'h2)
    else $error("third slot not chosen");

  AST_TICK_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick |=> selected_slot == $past(next_slot))
    else $error("selection not refreshed");

  AST_RESULTS_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick |=> cond_results == $past(results))
    else $error("condition results not refreshed");

  // Between ticks the output must hold, or consumers would see glitches.
  AST_HOLD_VALUE: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && !update_tick |=> $stable(out_value))
    else $error("output moved without a tick");

  AST_PASS_THROUGH: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick |=> out_value == $past(sel_tab.value))
    else $error("output differs from table");

  AST_TABLE_PICK: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick && hits[0] |=> out_value == $past(tables[table_ix[0]].value))
    else $error("first slot table not forwarded");

  AST_NO_SOURCE: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick && !sel_tab.has_source |=> !out_avail)
    else $error("sourceless table reported available");

  AST_SOURCE_AVAIL: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick && next_slot != NO_SLOT && sel_tab.has_source |=> out_avail)
    else $error("sourced table reported unavailable");

  AST_NONE_UNAVAIL: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && update_tick && next_slot == NO_SLOT |=> !out_avail)
    else $error("output available with no slot");

  // ==========================================================================
  // Checks on condition evaluation
  AST_NA_UNUSED: assert property (@(posedge sys_clk) disable iff (rst)
    cond_cfg[0][0].src1 == SRC_NOT_USED |-> results[1:0] == RES_NA)
    else $error("unused first source not NA");

  AST_NA_SECOND: assert property (@(posedge sys_clk) disable iff (rst)
    cond_cfg[0][0].src2 == SRC_NOT_USED |-> results[1:0] == RES_NA)
    else $error("unused second source not NA");

  // A write without two valid sources must leave the operator untouched.
  AST_OP_STAYS_EQ: assert property (@(posedge sys_clk) disable iff (rst)
    cfg_write && cfg_slot == 2'h0 && cfg_cond == 2'h0 && !op_ok |=> cond_cfg[0][0].op == $past(cond_cfg[0][0].op))
    else $error("operator changed without sources");

  // ==========================================================================
  // Checks on the combining operators
  AST_DEFAULT_HIT: assert property (@(posedge sys_clk) disable iff (rst)
    combine[2] == COMB_DEFAULT |-> hits[2])
    else $error("default slot missed");

  AST_ALL_AND_NA: assert property (@(posedge sys_clk) disable iff (rst)
    combine[0] == COMB_ALL_AND && results[5:0] == {3{RES_NA}} |-> hits[0])
    else $error("NA not counted true in all-AND");

  AST_ALL_AND_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
    combine[1] == COMB_ALL_AND && results[7:6] == RES_FALSE |-> !hits[1])
    else $error("false condition did not block all-AND");

  AST_ALL_OR_HIT: assert property (@(posedge sys_clk) disable iff (rst)
    combine[0] == COMB_ALL_OR && results[1:0] == RES_TRUE |-> hits[0])
    else $error("true condition missed in all-OR");

  AST_ALL_OR_MISS: assert property (@(posedge sys_clk) disable iff (rst)
    combine[0] == COMB_ALL_OR && results[1:0] == RES_ERROR && results[5:2] == {2{RES_NA}} |-> !hits[0])
    else $error("error or NA counted true in all-OR");

  AST_AND_OR_HIT: assert property (@(posedge sys_clk) disable iff (rst)
    combine[0] == COMB_AND_OR && results[5:4] == RES_TRUE |-> hits[0])
    else $error("third condition ignored in and-or");

  AST_OR_AND_MISS: assert property (@(posedge sys_clk) disable iff (rst)
    combine[0] == COMB_OR_AND && results[5:4] != RES_TRUE |-> !hits[0])
    else $error("or-and selected without third condition");

  COV_SLOT0:     cover property (@(posedge sys_clk) enabled && selected_slot == 2'h0);
  COV_SLOT1:     cover property (@(posedge sys_clk) enabled && selected_slot == 2'h1);
  COV_SLOT2:     cover property (@(posedge sys_clk) enabled && selected_slot == 2'h2);
  COV_NONE:      cover property (@(posedge sys_clk) enabled && selected_slot == 2'h3);
  COV_NO_SOURCE: cover property (@(posedge sys_clk) enabled && selected_slot != 2'h3 && !out_avail);

endmodule
`default_nettype wire

// ### hw/selector_pkg.sv
package selector_pkg;

  // ==========================================================================
  // Sizes
  localparam int TABLE_COUNT = 8;
  localparam int SLOT_COUNT  = 3;
  localparam int COND_COUNT  = 3;
  localparam int VALUE_W     = 32;
  localparam int SRC_W       = 4;
  localparam int INST_W      = 4;

  // ==========================================================================
  // Argument source codes
  localparam logic [3:0] SRC_NOT_USED = 4'h0;
  localparam logic [3:0] SRC_CONSTANT = 4'h1;

  // ==========================================================================
  // Comparison operator codes
  localparam logic [2:0] CMP_EQ = 3'h0;
  localparam logic [2:0] CMP_NE = 3'h1;
  localparam logic [2:0] CMP_GT = 3'h2;
  localparam logic [2:0] CMP_GE = 3'h3;
  localparam logic [2:0] CMP_LT = 3'h4;
  localparam logic [2:0] CMP_LE = 3'h5;

  // ==========================================================================
  // Condition result codes
  localparam logic [1:0] RES_FALSE = 2'h0;
  localparam logic [1:0] RES_TRUE  = 2'h1;
  localparam logic [1:0] RES_ERROR = 2'h2;
  localparam logic [1:0] RES_NA    = 2'h3;

  // ==========================================================================
  // Combining operator codes and reset values
  localparam logic [2:0] COMB_DEFAULT = 3'h0;
  localparam logic [2:0] COMB_ALL_AND = 3'h1;
  localparam logic [2:0] COMB_ALL_OR  = 3'h2;
  localparam logic [2:0] COMB_AND_OR  = 3'h3;
  localparam logic [2:0] COMB_OR_AND  = 3'h4;
  localparam logic [1:0] NO_SLOT      = 2'h3;

  // One argument as seen from the function block that feeds it.
  typedef struct packed {
    logic [VALUE_W-1:0] value;
    logic               error;
    logic               avail;
  } arg_t;

  // One lookup table output.
  typedef struct packed {
    logic [VALUE_W-1:0] value;
    logic               has_source;
  } table_out_t;

  // Configuration of one condition.
  typedef struct packed {
    logic [SRC_W-1:0]   src1;
    logic [INST_W-1:0]  num1;
    logic [SRC_W-1:0]   src2;
    logic [INST_W-1:0]  num2;
    logic [VALUE_W-1:0] constant;
    logic [2:0]         op;
  } cond_cfg_t;

endpackage

// ### verification/arg_source_model.sv
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// Stand-in for the function blocks and lookup tables around the selector.
module arg_source_model
  import selector_pkg::*;
(
  input  wire logic [15:0]                   err_mask,
  input  wire logic [15:0]                   na_mask,
  input  wire logic [7:0]                    nosrc_mask,
  output var  arg_t [TABLE_COUNT*2-1:0]      block_outputs,
  output var  table_out_t [TABLE_COUNT-1:0]  tables
);
  // Distinct values per index expose a wrong argument or table pick.
  always_comb begin
    for (int i = 0; i < TABLE_COUNT*2; i++) begin
      block_outputs[i].value = 32'h0000_1000 + 32'(i);
      block_outputs[i].error = err_mask[i];
      block_outputs[i].avail = !na_mask[i];
    end
    for (int i = 0; i < TABLE_COUNT; i++) begin
      tables[i].value      = 32'h00a0_0000 + 32'(i);
      tables[i].has_source = !nosrc_mask[i];
    end
  end
endmodule
`default_nettype wire

// ### verification/test_conditional_table_selector.sv
`timescale 1ns/10ps
`default_nettype none
module test_conditional_table_selector
  import selector_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, enable_in = 1'b0, update_tick = 1'b0, cfg_write = 1'b0;
  logic [1:0] cfg_slot = 2'h0, cfg_cond = 2'h0, selected_slot;
  logic [2:0] cfg_combine = 3'h1, cfg_table = 3'h0;
  cond_cfg_t cfg_cond_data = '0;
  arg_t [15:0] block_outputs;
  table_out_t [7:0] tables;
  logic [15:0] err_mask = 16'h0, na_mask = 16'h0;
  logic [7:0] nosrc_mask = 8'h0;
  logic enabled, out_avail;
  logic [31:0] out_value;
  logic [17:0] cond_results;
  int n_fail = 0, n_compared = 0;
  conditional_table_selector DUT (.sys_clk(sys_clk), .rst(rst), .enable_in(enable_in),
    .update_tick(update_tick), .cfg_write(cfg_write), .cfg_slot(cfg_slot),
    .cfg_cond(cfg_cond), .cfg_cond_data(cfg_cond_data), .cfg_combine(cfg_combine),
    .cfg_table(cfg_table), .block_outputs(block_outputs), .tables(tables),
    .enabled(enabled), .selected_slot(selected_slot), .out_value(out_value),
    .out_avail(out_avail), .cond_results(cond_results));
  arg_source_model model (.err_mask(err_mask), .na_mask(na_mask), .nosrc_mask(nosrc_mask),
    .block_outputs(block_outputs), .tables(tables));
  always #25 sys_clk = ~sys_clk;
  // ======================================================================
  // Helpers
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_code(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: code %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  // The argument is block output 2, whose value is 32'h1002.
  task automatic write_cond(input logic [1:0] s, c, input logic [3:0] s2,
                            input logic [31:0] k, input logic [2:0] op, comb, tbl);
    cfg_slot = s;
    cfg_cond = c;
    cfg_combine = comb;
    cfg_table = tbl;
    cfg_cond_data = '{src1: 4'h2, num1: 4'h1, src2: s2, num2: 4'h0, constant: k, op: op};
    cfg_write = 1'b1;
    step();
    cfg_write = 1'b0;
  endtask
  task automatic tick();
    update_tick = 1'b1;
    step();
    update_tick = 1'b0;
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ======================================================================
  // Scenarios
  task automatic test_reset();
    repeat (3) step();
    cmp_code(18'(enabled), 18'h0);
    cmp_code(18'(out_avail), 18'h0);
    cmp_code(cond_results, 18'h3ffff);
    rst = 1'b0;
    enable_in = 1'b1;
    step();
    cmp_code(18'(enabled), 18'h1);
    tick();
    cmp_code(18'(selected_slot), 18'h0);
    cmp_word(out_value, 32'h00a0_0000);
    cmp_code(18'(out_avail), 18'h1);
    $display("reset test done");
  endtask
  task automatic test_ops();
    logic t;
    for (int k = 1; k <= 3; k++) begin
      for (int op = 0; op < 6; op++) begin
        case (op)
          0: t = 32'h1002 == 32'h1000 + k;
          1: t = 32'h1002 != 32'h1000 + k;
          2: t = 32'h1002 > 32'h1000 + k;
          3: t = 32'h1002 >= 32'h1000 + k;
          4: t = 32'h1002 < 32'h1000 + k;
          default: t = 32'h1002 <= 32'h1000 + k;
        endcase
        write_cond(2'h0, 2'h0, 4'h1, 32'h1000 + 32'(k), 3'(op), COMB_ALL_OR, 3'h5);
        tick();
        cmp_code(18'(cond_results[1:0]), 18'(t ? RES_TRUE : RES_FALSE));
        cmp_word(out_value, t ? 32'h00a0_0005 : 32'h00a0_0001);
      end
    end
    err_mask = 16'h0004;
    tick();
    cmp_code(18'(cond_results[1:0]), 18'(RES_ERROR));
    cmp_code(18'(selected_slot), 18'h1);
    na_mask = 16'h0004;
    err_mask = 16'h0;
    tick();
    cmp_code(18'(cond_results[1:0]), 18'(RES_NA));
    na_mask = 16'h0;
    write_cond(2'h0, 2'h0, SRC_NOT_USED, 32'h1002, CMP_EQ, COMB_ALL_OR, 3'h5);
    tick();
    cmp_code(18'(cond_results[1:0]), 18'(RES_NA));
    $display("operator test done");
  endtask
  task automatic test_combine();
    logic [2:0] p;
    logic e;
    write_cond(2'h1, 2'h0, 4'h1, 32'h1002, CMP_NE, COMB_ALL_AND, 3'h1);
    for (int comb = 1; comb <= 4; comb++) begin
      for (int i = 0; i < 4; i++) begin
        p = (i == 0) ? 3'h1 : (i == 1) ? 3'h4 : (i == 2) ? 3'h5 : 3'h7;
        for (int c = 0; c < 3; c++)
          write_cond(2'h0, 2'(c), 4'h1, 32'h1002, p[c] ? CMP_EQ : CMP_NE, 3'(comb), 3'h3);
        e = (comb == 1) ? &p : (comb == 2) ? |p : (comb == 3) ? ((p[0] & p[1]) | p[2])
          : ((p[0] | p[1]) & p[2]);
        tick();
        cmp_code(18'(selected_slot), e ? 18'h0 : 18'h2);
        cmp_word(out_value, e ? 32'h00a0_0003 : 32'h00a0_0002);
      end
    end
    nosrc_mask = 8'h08;
    tick();
    cmp_code(18'(out_avail), 18'h0);
    enable_in = 1'b0;
    step();
    tick();
    cmp_code(18'(selected_slot), 18'h3);
    $display("combine test done");
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    results();
  end
  initial begin
    test_reset();
    test_ops();
    test_combine();
    results();
  end
endmodule
`default_nettype wire
